// [src/nvmcic_pkg.sv]
/*
  Shared constants and types of the memory command-issue front end.
  Assumes both ends and the bench import it whole.
*/
package nvmcic_pkg;
  // Register byte offsets on the peripheral-side register port
  localparam logic [7:0] OFF_CMD_CTRL = 8'h00;
  localparam logic [7:0] OFF_CTRL2 = 8'h04;
  localparam logic [7:0] OFF_INT_FLAGS = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;

  // Command control fields
  localparam logic [7:0] EXEC_KEY = 8'hA5;
  localparam int CMD_LSB = 0;
  localparam int CMD_W = 7;
  localparam int KEY_LSB = 8;
  localparam int KEY_W = 8;
  localparam logic [15:0] CMD_CTRL_RESET = 16'h0000;

  // Second control fields
  localparam int C2_EN_BIT = 0;
  localparam int C2_WS_LSB = 1;
  localparam int C2_WS_W = 4;
  localparam int C2_SPM_LSB = 8;
  localparam int C2_SPM_W = 2;
  localparam logic [3:0] WS_RESET = 4'h0;
  localparam logic [1:0] SPM_RESET = 2'h0;
  localparam logic [1:0] SPM_OFF = 2'h3;

  // Flag and status bit positions
  localparam int IF_READY_BIT = 0;
  localparam int ST_PROGRAMMING_ERROR_BIT = 2;

  typedef enum logic [1:0] {DS_IDLE, DS_PEND, DS_EXEC} nvmcic_dev_st_e;

  typedef enum logic [3:0] {
    HS_IDLE, HS_POLL, HS_POLL_W, HS_CMD, HS_CMD_W, HS_ST, HS_ST_W,
    HS_CLR, HS_CLR_W, HS_DIS, HS_DIS_W, HS_CFG, HS_CFG_W
  } nvmcic_host_st_e;
endpackage : nvmcic_pkg

// [src/nvmcic_if.sv]
/*
  Register port between the software-side issuer and the controller.
  Assumes one clock, ref_clk, shared by both ends.
*/
interface nvmcic_if;
  logic req_valid;
  logic req_write;
  logic [7:0] req_addr;
  logic [3:0] req_be;
  logic [31:0] req_wdata;
  logic rsp_valid;
  logic rsp_err;
  logic [31:0] rsp_rdata;

  modport dev (
    input req_valid, req_write, req_addr, req_be, req_wdata,
    output rsp_valid, rsp_err, rsp_rdata
  );
  modport host (
    output req_valid, req_write, req_addr, req_be, req_wdata,
    input rsp_valid, rsp_err, rsp_rdata
  );
endinterface : nvmcic_if

// [src/nvmcic_dev.sv]
/*
  Controller end: command register with key check, error status,
  deferral behind memory-side fetches, sleep power control, and the
  read-back of second control, interrupt flags and status.
  Only one command is in flight; a second one is refused, not queued.
  Assumes the array reports busy and done, and one clock for all.
  Assumes memory-side fetch and write protection arrive as levels
  already settled in this clock domain.
*/
module nvmcic_dev
  import nvmcic_pkg::*;
(
  input wire logic ref_clk, // 250 MHz clock
  input wire logic srst, // Synchronous reset, active high
  nvmcic_if.dev bus, // Register port
  input wire logic ahb_access, // Memory-side fetch this cycle
  input wire logic array_busy, // Array still working
  input wire logic array_done, // Array finished command, pulse
  input wire logic pac_wp, // Write protection active
  input wire logic sleep, // Device in sleep
  input wire logic standby, // Device in standby
  output logic array_start, // Start command, pulse
  output logic [6:0] array_cmd, // Command code to array
  output logic [3:0] wait_states, // Fetch wait states
  output logic module_en, // Module enable
  output logic ready, // Ready flag level
  output logic low_power, // Array low-power request
  output logic page_buf_lost, // Page buffer dropped, pulse
  output logic wake_req // Wake request, pulse
);

  typedef struct packed {
    nvmcic_dev_st_e st;
    logic [CMD_W-1:0] cmd;
    logic issued;
    logic programming_error;
    logic en;
    logic [C2_WS_W-1:0] ws;
    logic [C2_SPM_W-1:0] spm;
    logic rsp_v;
    logic rsp_e;
    logic [31:0] rdata;
    logic start;
    logic lp;
    logic lost;
    logic wake;
  } nvmcic_dev_s;

  nvmcic_dev_s q;
  nvmcic_dev_s d;

  logic wr;
  logic hit_cc;
  logic hit_c2;
  logic hit_if;
  logic hit_st;
  logic key_wr;
  logic good;
  logic busy_err;
  logic clr_pe;
  logic lp_now;
  logic [KEY_W-1:0] key_rd;
  logic key_ok;
  logic both_lanes;
  logic path_free;

  // Address decode and write qualification
  assign wr = bus.req_valid & bus.req_write;
  assign hit_cc = bus.req_addr == OFF_CMD_CTRL;
  assign hit_c2 = bus.req_addr == OFF_CTRL2;
  assign hit_if = bus.req_addr == OFF_INT_FLAGS;
  assign hit_st = bus.req_addr == OFF_STATUS;
  // A write touching the key lane counts as a command attempt unless write protection is active
  assign key_wr = wr & hit_cc & ~pac_wp & bus.req_be[1];
  // Key compare looks at lane one only
  assign key_ok = bus.req_wdata[KEY_LSB +: KEY_W] == EXEC_KEY;
  // A key without its code lane is treated like a wrong key
  assign both_lanes = bus.req_be[1] & bus.req_be[0];
  assign good = key_wr & both_lanes & key_ok;
  // Launch only when neither a fetch nor the array holds the port
  assign path_free = ~ahb_access & ~array_busy;
  // A valid key while a command is still held or running
  assign busy_err = good & (q.st != DS_IDLE);
  // Status is outside write protection, so no pac_wp term
  assign clr_pe = wr & hit_st & bus.req_be[0] & bus.req_wdata[ST_PROGRAMMING_ERROR_BIT];
  // Standby forces low power whatever the mode field says
  assign lp_now = standby | (sleep & (q.spm != SPM_OFF));
  // Bit 0 of the key field shows that no command was ever taken
  assign key_rd = {{(KEY_W-1){1'b0}}, ~q.issued};

  // Next-state logic
  always_comb begin
    d = q;
    d.start = 1'b0;
    d.wake = 1'b0;
    // Sequencer. No debug input exists, so a core halted by a debugger
    // leaves command launch, deferral and completion untouched
    unique case (q.st)
      DS_IDLE: begin
        if (good) begin
          d.cmd = bus.req_wdata[CMD_LSB +: CMD_W];
          d.issued = 1'b1;
          // Fetch in the same cycle defers the command
          if (!path_free) begin
            d.st = DS_PEND;
          end else begin
            d.st = DS_EXEC;
            d.start = 1'b1;
          end
        end
      end
      // Held command waits here; the code register keeps it meanwhile
      DS_PEND: begin
        if (path_free) begin
          d.st = DS_EXEC;
          d.start = 1'b1;
        end
      end
      // Ready stays low until the array says done; there is no timeout,
      // so an array that never answers keeps the port busy
      DS_EXEC: begin
        if (array_done) begin
          d.st = DS_IDLE;
          d.wake = sleep;
        end
      end
    endcase
    // Error flag: a set in the clearing cycle wins,
    // so a refused write is never lost to a racing clear
    d.programming_error = (q.programming_error & ~clr_pe) | (key_wr & ~good) | busy_err;
    // Second control; fields are enable-protected
    // The enable bit itself stays writable so software can switch off
    if (wr & hit_c2 & ~pac_wp) begin
      if (bus.req_be[0]) begin
        d.en = bus.req_wdata[C2_EN_BIT];
        if (~q.en) begin
          d.ws = bus.req_wdata[C2_WS_LSB +: C2_WS_W];
        end
      end
      if (bus.req_be[1] & ~q.en) begin
        d.spm = bus.req_wdata[C2_SPM_LSB +: C2_SPM_W];
      end
    end
    // Read answer one cycle after the request, any lane width
    // Reads ignore byte enables; the reader drops lanes it did not ask for
    d.rsp_v = bus.req_valid;
    d.rsp_e = bus.req_valid & ~(hit_cc | hit_c2 | hit_if | hit_st);
    d.rdata = 32'h0000_0000;
    if (bus.req_valid & ~bus.req_write) begin
      if (hit_cc) begin
        d.rdata[KEY_LSB +: KEY_W] = key_rd;
        d.rdata[CMD_LSB +: CMD_W] = q.cmd;
      end else if (hit_c2) begin
        d.rdata[C2_EN_BIT] = q.en;
        d.rdata[C2_WS_LSB +: C2_WS_W] = q.ws;
        d.rdata[C2_SPM_LSB +: C2_SPM_W] = q.spm;
      end else if (hit_if) begin
        d.rdata[IF_READY_BIT] = q.st == DS_IDLE;
      end else if (hit_st) begin
        d.rdata[ST_PROGRAMMING_ERROR_BIT] = q.programming_error;
      end
    end
    // Low-power request, buffer loss on each entry
    // The buffer drops in standby too, even with the power mode off
    d.lp = lp_now;
    d.lost = lp_now & ~q.lp;
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '{st: DS_IDLE, cmd: CMD_CTRL_RESET[CMD_W-1:0], issued: 1'b0,
             programming_error: 1'b0, en: 1'b0, ws: WS_RESET, spm: SPM_RESET,
             rsp_v: 1'b0, rsp_e: 1'b0, rdata: 32'h0000_0000,
             start: 1'b0, lp: 1'b0, lost: 1'b0, wake: 1'b0};
    end else begin
      q <= d;
    end
  end

  // Outputs all from flops; ready is a plain decode of the state
  // register, so it needs no flop of its own
  assign bus.rsp_valid = q.rsp_v;
  assign bus.rsp_err = q.rsp_e;
  assign bus.rsp_rdata = q.rdata;
  assign array_start = q.start;
  assign array_cmd = q.cmd;
  assign wait_states = q.ws;
  assign module_en = q.en;
  assign ready = q.st == DS_IDLE;
  assign low_power = q.lp;
  assign page_buf_lost = q.lost;
  assign wake_req = q.wake;

endmodule : nvmcic_dev

// [src/nvmcic_host.sv]
/*
  Software-side issuer: polls ready, writes key and code in one access,
  checks and clears the error bit, programs wait states and power mode.
  Assumes the controller answers every request one cycle later.
*/
module nvmcic_host
  import nvmcic_pkg::*;
(
  input wire logic ref_clk, // 250 MHz clock
  input wire logic srst, // Synchronous reset, active high
  nvmcic_if.host bus, // Register port
  input wire logic cmd_req, // Issue command, pulse
  input wire logic [6:0] cmd_code, // Command code
  input wire logic cfg_req, // Program configuration, pulse
  input wire logic [3:0] cfg_ws, // Wait states
  input wire logic [1:0] cfg_spm, // Sleep power mode
  output logic busy, // Sequence running
  output logic cmd_done, // Command accepted, pulse
  output logic cmd_err, // Command refused, pulse
  output logic cfg_done // Configuration written, pulse
);

  typedef struct packed {
    nvmcic_host_st_e st;
    logic [CMD_W-1:0] code;
    logic [C2_WS_W-1:0] ws;
    logic [C2_SPM_W-1:0] spm;
    logic rv;
    logic rw;
    logic [7:0] ra;
    logic [3:0] rbe;
    logic [31:0] rd;
    logic done;
    logic err;
    logic cdone;
  } nvmcic_host_s;

  nvmcic_host_s q;
  nvmcic_host_s d;

  // Sequencer; each request is one cycle, then waits for the answer
  always_comb begin
    d = q;
    d.rv = 1'b0;
    d.done = 1'b0;
    d.err = 1'b0;
    d.cdone = 1'b0;
    unique case (q.st)
      HS_IDLE: begin
        if (cmd_req) begin
          d.code = cmd_code;
          d.st = HS_POLL;
        end else if (cfg_req) begin
          d.ws = cfg_ws;
          d.spm = cfg_spm;
          d.st = HS_DIS;
        end
      end
      HS_POLL: begin
        d = q;
        d.rv = 1'b1; d.rw = 1'b0; d.ra = OFF_INT_FLAGS; d.rbe = 4'h1;
        d.rd = 32'h0000_0000; d.done = 1'b0; d.err = 1'b0; d.cdone = 1'b0;
        d.st = HS_POLL_W;
      end
      HS_POLL_W: begin
        // Issue only once ready reads one
        if (bus.rsp_valid) begin
          d.st = bus.rsp_rdata[IF_READY_BIT] ? HS_CMD : HS_POLL;
        end
      end
      HS_CMD: begin
        // Key and code in the same access
        d.rv = 1'b1; d.rw = 1'b1; d.ra = OFF_CMD_CTRL; d.rbe = 4'h3;
        d.rd = {16'h0000, EXEC_KEY, 1'b0, q.code};
        d.st = HS_CMD_W;
      end
      HS_CMD_W: begin
        if (bus.rsp_valid) begin
          d.st = HS_ST;
        end
      end
      HS_ST: begin
        d.rv = 1'b1; d.rw = 1'b0; d.ra = OFF_STATUS; d.rbe = 4'h1;
        d.st = HS_ST_W;
      end
      HS_ST_W: begin
        if (bus.rsp_valid) begin
          if (bus.rsp_rdata[ST_PROGRAMMING_ERROR_BIT]) begin
            d.st = HS_CLR;
          end else begin
            d.st = HS_IDLE;
            d.done = 1'b1;
          end
        end
      end
      HS_CLR: begin
        d.rv = 1'b1; d.rw = 1'b1; d.ra = OFF_STATUS; d.rbe = 4'h1;
        d.rd = 32'h0000_0000;
        d.rd[ST_PROGRAMMING_ERROR_BIT] = 1'b1;
        d.st = HS_CLR_W;
      end
      HS_CLR_W: begin
        if (bus.rsp_valid) begin
          d.st = HS_IDLE;
          d.err = 1'b1;
        end
      end
      HS_DIS: begin
        // Disable first: protected fields only take writes while off
        d.rv = 1'b1; d.rw = 1'b1; d.ra = OFF_CTRL2; d.rbe = 4'h1;
        d.rd = 32'h0000_0000;
        d.st = HS_DIS_W;
      end
      HS_DIS_W: begin
        if (bus.rsp_valid) begin
          d.st = HS_CFG;
        end
      end
      HS_CFG: begin
        // Wait states land before any clock change is allowed
        d.rv = 1'b1; d.rw = 1'b1; d.ra = OFF_CTRL2; d.rbe = 4'h3;
        d.rd = 32'h0000_0000;
        d.rd[C2_EN_BIT] = 1'b1;
        d.rd[C2_WS_LSB +: C2_WS_W] = q.ws;
        d.rd[C2_SPM_LSB +: C2_SPM_W] = q.spm;
        d.st = HS_CFG_W;
      end
      HS_CFG_W: begin
        if (bus.rsp_valid) begin
          d.st = HS_IDLE;
          d.cdone = 1'b1;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '{st: HS_IDLE, code: 7'h00, ws: WS_RESET, spm: SPM_RESET,
             rv: 1'b0, rw: 1'b0, ra: 8'h00, rbe: 4'h0, rd: 32'h0000_0000,
             done: 1'b0, err: 1'b0, cdone: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign bus.req_valid = q.rv;
  assign bus.req_write = q.rw;
  assign bus.req_addr = q.ra;
  assign bus.req_be = q.rbe;
  assign bus.req_wdata = q.rd;
  assign busy = q.st != HS_IDLE;
  assign cmd_done = q.done;
  assign cmd_err = q.err;
  assign cfg_done = q.cdone;

endmodule : nvmcic_host

// [testbench/nvmcic_props.sv]
/*
  Checker on the register port between issuer and controller.
  Assumes one clock and the bench wiring the first interface to it.
*/
module nvmcic_props
  import nvmcic_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic srst, // Sync reset
  input wire logic req_valid, // Request strobe
  input wire logic req_write, // Write flag
  input wire logic [7:0] req_addr, // Byte offset
  input wire logic [3:0] req_be, // Byte enables
  input wire logic [31:0] req_wdata, // Write data
  input wire logic rsp_valid, // Answer strobe
  input wire logic rsp_err, // Unmapped flag
  input wire logic [31:0] rsp_rdata // Read data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mapped;
  logic rd_flags_q, rd_flags_d, poll_ok_q, poll_ok_d;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Offsets that must answer without error
  assign mapped = req_addr inside {OFF_CMD_CTRL, OFF_CTRL2, OFF_INT_FLAGS, OFF_STATUS};
  // A ready poll arms one command write; the write itself disarms it
  always_comb begin
    rd_flags_d = req_valid && !req_write && req_addr == OFF_INT_FLAGS;
    poll_ok_d = poll_ok_q;
    if (rd_flags_q && rsp_valid && rsp_rdata[IF_READY_BIT])
      poll_ok_d = 1'h1;
    if (req_valid && req_write && req_addr == OFF_CMD_CTRL)
      poll_ok_d = 1'h0;
  end
  // Helper registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rd_flags_q <= 1'h0;
      poll_ok_q <= 1'h0;
    end else begin
      rd_flags_q <= rd_flags_d;
      poll_ok_q <= poll_ok_d;
    end
  end
  a_rsp_one_late: assert property (req_valid |=> rsp_valid)
    else $error("request not answered next cycle");
  a_rsp_has_cause: assert property (rsp_valid |-> $past(req_valid))
    else $error("answer without request");
  a_err_needs_rsp: assert property (rsp_err |-> rsp_valid)
    else $error("error outside answer");
  a_mapped_no_err: assert property (req_valid && mapped |-> ##1 !rsp_err)
    else $error("mapped access refused");
  a_write_no_data: assert property (req_valid && req_write |=> rsp_rdata == 32'h0)
    else $error("write returned data");
  a_cmd_one_access: assert property (req_valid && req_write && req_addr == OFF_CMD_CTRL
    |-> req_be[1:0] == 2'h3 && req_wdata[15:8] == EXEC_KEY)
    else $error("key and code split");
  a_issue_when_ready: assert property (req_valid && req_write && req_addr == OFF_CMD_CTRL
    |-> poll_ok_q)
    else $error("command without ready poll");
  a_flags_ready_only: assert property (rd_flags_q |-> rsp_rdata[31:1] == 31'h0)
    else $error("stray flag bits");
  a_status_err_only: assert property (req_valid && !req_write && req_addr == OFF_STATUS
    |=> (rsp_rdata & ~32'h4) == 32'h0)
    else $error("stray status bits");
  c_cmd_write: cover property (req_valid && req_write && req_addr == OFF_CMD_CTRL);
  c_cfg_write: cover property (req_valid && req_write && req_addr == OFF_CTRL2);
  c_poll_busy: cover property (rd_flags_q && rsp_valid && !rsp_rdata[0]);
endmodule : nvmcic_props

// [testbench/test_nvm_command_issue_control.sv]
/*
  Bench: issuer joined to controller, plus a second controller driven directly.
  Assumes package, interface and both ends compiled first.
*/
module test_nvm_command_issue_control;
  timeunit 1ns;
  timeprecision 1ps;
  import nvmcic_pkg::*;
  logic ref_clk, srst, cmd_req, cfg_req, ahb_access, array_busy, array_done, pac_wp;
  logic sleep, standby, busy, cmd_done, cmd_err, cfg_done, array_start, module_en;
  logic ready, low_power, page_buf_lost, wake_req, b_en, b_ready, er;
  logic [6:0] cmd_code, array_cmd;
  logic [3:0] cfg_ws, wait_states, b_ws;
  logic [1:0] cfg_spm;
  logic [31:0] rd;
  int n_fail, comparisons, n_start, n_done, n_err, n_cfg, n_lost, n_wake, s, d;
  nvmcic_if bus1();
  nvmcic_if bus2();
  nvmcic_host nvmcic_host_i(.ref_clk(ref_clk), .srst(srst), .bus(bus1), .cmd_req(cmd_req),
    .cmd_code(cmd_code), .cfg_req(cfg_req), .cfg_ws(cfg_ws), .cfg_spm(cfg_spm), .busy(busy),
    .cmd_done(cmd_done), .cmd_err(cmd_err), .cfg_done(cfg_done));
  nvmcic_dev nvmcic_dev_i(.ref_clk(ref_clk), .srst(srst), .bus(bus1), .ahb_access(ahb_access),
    .array_busy(array_busy), .array_done(array_done), .pac_wp(pac_wp), .sleep(sleep),
    .standby(standby), .array_start(array_start), .array_cmd(array_cmd),
    .wait_states(wait_states), .module_en(module_en), .ready(ready), .low_power(low_power),
    .page_buf_lost(page_buf_lost), .wake_req(wake_req));
  // Second controller: the bench breaks the issuing rules on purpose here
  nvmcic_dev nvmcic_dev_b_i(.ref_clk(ref_clk), .srst(srst), .bus(bus2), .ahb_access(ahb_access),
    .array_busy(array_busy), .array_done(array_done), .pac_wp(pac_wp), .sleep(sleep),
    .standby(standby), .array_start(), .array_cmd(), .wait_states(b_ws), .module_en(b_en),
    .ready(b_ready), .low_power(), .page_buf_lost(), .wake_req());
  nvmcic_props nvmcic_props_i(.ref_clk(ref_clk), .srst(srst), .req_valid(bus1.req_valid),
    .req_write(bus1.req_write), .req_addr(bus1.req_addr), .req_be(bus1.req_be),
    .req_wdata(bus1.req_wdata), .rsp_valid(bus1.rsp_valid), .rsp_err(bus1.rsp_err),
    .rsp_rdata(bus1.rsp_rdata));
  // Clock, 4 ns period
  initial begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end
  // One-cycle pulses are counted at the edge that samples them
  always @(posedge ref_clk) begin
    n_start += (array_start === 1'h1);
    n_done += (cmd_done === 1'h1);
    n_err += (cmd_err === 1'h1);
    n_cfg += (cfg_done === 1'h1);
    n_lost += (page_buf_lost === 1'h1);
    n_wake += (wake_req === 1'h1);
  end
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input bit ok, input string m);
    comparisons++;
    if (!ok) begin
      n_fail++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  // One access on the second port; request held until its answer is sampled
  task automatic acc(input bit w, input logic [7:0] a, input logic [3:0] be,
      input logic [31:0] dt);
    @(negedge ref_clk);
    bus2.req_valid = 1'h1;
    bus2.req_write = w;
    bus2.req_addr = a;
    bus2.req_be = be;
    bus2.req_wdata = dt;
    @(negedge ref_clk);
    bus2.req_valid = 1'h0;
    rd = bus2.rsp_rdata;
    er = bus2.rsp_err;
    chk(bus2.rsp_valid === 1'h1, "no answer");
  endtask : acc
  task automatic issue(input logic [6:0] c);
    @(negedge ref_clk);
    cmd_code = c;
    cmd_req = 1'h1;
    @(negedge ref_clk);
    cmd_req = 1'h0;
  endtask : issue
  task automatic pulse_done;
    @(negedge ref_clk);
    array_done = 1'h1;
    @(negedge ref_clk);
    array_done = 1'h0;
  endtask : pulse_done
  // Bounded wait for a pulse counter to move
  task automatic wait_inc(ref int c, input int b);
    repeat (60) if (c == b) @(negedge ref_clk);
  endtask : wait_inc
  task automatic set_config(input logic [3:0] ws, input logic [1:0] spm);
    s = n_cfg;
    cfg_ws = ws;
    cfg_spm = spm;
    cfg_req = 1'h1;
    @(negedge ref_clk);
    cfg_req = 1'h0;
    wait_inc(n_cfg, s);
    chk(wait_states === ws && module_en === 1'h1, "config");
  endtask : set_config
  task automatic t_regs;
    acc(0, OFF_CMD_CTRL, 4'h3, 32'h0);
    chk(rd === 32'h0000_0100, "key bit after reset");
    acc(0, 8'h08, 4'hF, 32'h0);
    chk(er === 1'h1 && b_ready === 1'h1, "unmapped");
    acc(1, OFF_CTRL2, 4'h1, 32'h0000_000B);
    acc(1, OFF_CTRL2, 4'h1, 32'h0000_0013);
    chk(b_ws === 4'h5 && b_en === 1'h1, "protected field");
    pac_wp = 1'h1;
    acc(1, OFF_CTRL2, 4'h1, 32'h0);
    chk(b_en === 1'h1, "write protection");
    pac_wp = 1'h0;
    $display("test regs done");
  endtask : t_regs
  task automatic t_key;
    acc(1, OFF_CMD_CTRL, 4'h3, 32'h0000_5A05);
    acc(0, OFF_STATUS, 4'hF, 32'h0);
    chk(rd === 32'h4 && b_ready === 1'h1, "wrong key");
    pac_wp = 1'h1;
    acc(1, OFF_STATUS, 4'h1, 32'h4);
    acc(0, OFF_STATUS, 4'hF, 32'h0);
    chk(rd === 32'h0, "status clear");
    pac_wp = 1'h0;
    acc(1, OFF_CMD_CTRL, 4'h2, 32'h0000_A500);
    acc(0, OFF_STATUS, 4'hF, 32'h0);
    chk(rd === 32'h4 && b_ready === 1'h1, "key alone");
    acc(1, OFF_STATUS, 4'h1, 32'h4);
    acc(1, OFF_CMD_CTRL, 4'h3, 32'h0000_A505);
    acc(0, OFF_CMD_CTRL, 4'h3, 32'h0);
    chk(rd === 32'h5 && b_ready === 1'h0, "keyed command");
    acc(1, OFF_CMD_CTRL, 4'h3, 32'h0000_A506);
    acc(0, OFF_STATUS, 4'hF, 32'h0);
    chk(rd === 32'h4, "overlap");
    pulse_done;
    acc(0, OFF_INT_FLAGS, 4'hF, 32'h0);
    chk(rd === 32'h1, "ready back");
    $display("test key done");
  endtask : t_key
  task automatic t_cmd;
    s = n_start;
    d = n_done;
    issue(7'h7F);
    wait_inc(n_start, s);
    chk(n_start == s + 1 && array_cmd === 7'h7F && ready === 1'h0, "launch");
    wait_inc(n_done, d);
    chk(n_done == d + 1 && n_err == 0, "host issue");
    d = n_done;
    issue(7'h01);
    repeat (20) @(negedge ref_clk);
    chk(n_done == d && busy === 1'h1, "issued while busy");
    pulse_done;
    wait_inc(n_done, d);
    chk(n_done == d + 1, "late issue");
    pulse_done;
    $display("test cmd done");
  endtask : t_cmd
  task automatic t_defer;
    // A fetch alone must defer; the array then holds it on its own
    ahb_access = 1'h1;
    s = n_start;
    d = n_done;
    issue(7'h22);
    wait_inc(n_done, d);
    chk(n_start == s && ready === 1'h0, "ran under fetch");
    ahb_access = 1'h0;
    array_busy = 1'h1;
    repeat (4) @(negedge ref_clk);
    chk(n_start == s, "ran while array busy");
    array_busy = 1'h0;
    repeat (4) @(negedge ref_clk);
    chk(n_start == s + 1 && array_cmd === 7'h22, "deferred lost");
    pulse_done;
    $display("test defer done");
  endtask : t_defer
  task automatic t_power;
    set_config(4'h3, SPM_OFF);
    sleep = 1'h1;
    repeat (3) @(negedge ref_clk);
    chk(low_power === 1'h0, "spm off");
    s = n_lost;
    standby = 1'h1;
    repeat (3) @(negedge ref_clk);
    chk(low_power === 1'h1 && n_lost == s + 1, "standby");
    standby = 1'h0;
    sleep = 1'h0;
    set_config(4'h6, SPM_RESET);
    sleep = 1'h1;
    repeat (3) @(negedge ref_clk);
    chk(low_power === 1'h1, "sleep power");
    s = n_wake;
    d = n_done;
    issue(7'h03);
    wait_inc(n_done, d);
    pulse_done;
    repeat (2) @(negedge ref_clk);
    chk(n_wake == s + 1, "no wake");
    sleep = 1'h0;
    $display("test power done");
  endtask : t_power
  // Run should need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    $display("[ERR] %0t watchdog", $time);
    tally_and_finish;
  end
  initial begin
    {srst, cmd_req, cfg_req, ahb_access, array_busy, array_done} = 6'h20;
    {pac_wp, sleep, standby, cmd_code, cfg_ws, cfg_spm} = 16'h0;
    {bus2.req_valid, bus2.req_write, bus2.req_addr, bus2.req_be} = 14'h0;
    bus2.req_wdata = 32'h0;
    repeat (12) @(negedge ref_clk);
    srst = 1'h0;
    t_regs;
    t_key;
    t_cmd;
    t_defer;
    t_power;
    tally_and_finish;
  end
endmodule : test_nvm_command_issue_control
